// ---- dv/counter_props.sv ----
module counter_props
  import rank_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] source_word_i,
  input wire logic       clear_store_i,
  input wire logic       transfer_store_i,
  input wire logic [2:0] upstream_word_i,
  input wire logic       load_shift_i,
  input wire logic       return_shift_i,
  input wire logic       rotate_shift_i,
  input wire logic       rank_copy_i,
  input wire logic [2:0] store_word_o,
  input wire logic [2:0] shift_word_o,
  input wire logic [8:0] count_o,
  input wire logic [2:0] carry_enable_o,
  input wire logic       phase_odd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_clr; clear_store_i ##1 !transfer_store_i |-> ##1 store_word_o == ZERO_WORD;
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_or; transfer_store_i && !clear_store_i |-> ##2
    store_word_o == ($past(store_word_o) | $past(source_word_i, 2)); endproperty
  a_or: assert property (p_or) else $error("or");
  property p_rot; load_shift_i ##1 (!load_shift_i && !return_shift_i) ##1 rotate_shift_i |-> ##2
    shift_word_o == {$past(upstream_word_i[1:0], 4), $past(upstream_word_i[2], 4)}; endproperty
  a_rot: assert property (p_rot) else $error("rot");
  property p_hold; !$past(rank_copy_i, 2) |-> $stable(count_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_cy; carry_enable_o == {&count_o[8:6], &count_o[5:3], &count_o[2:0]}; endproperty
  a_cy: assert property (p_cy) else $error("cy");
  property p_chn; $changed(count_o[8:3]) |-> $past(count_o[2:0]) == ONES_WORD; endproperty
  a_chn: assert property (p_chn) else $error("chn");
  property p_ph; $past(rst_n_i, 3) |-> phase_odd_o != $past(phase_odd_o); endproperty
  a_ph: assert property (p_ph) else $error("ph");
  property p_rst; disable iff (1'b0) !rst_n_i |=> {count_o, shift_word_o, store_word_o} == 15'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("rst");
endmodule
bind double_rank_counter_shifter counter_props u_props (.*);

// ---- dv/double_rank_counter_shifter_bench.sv ----
module double_rank_counter_shifter_bench
  import rank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int n; logic [8:0] c; logic [2:0] e;} row_t;
  row_t rows[7] = '{'{1, 9'h001, 3'h0}, '{6, 9'h007, 3'h1}, '{1, 9'h008, 3'h0},
    '{55, 9'h03F, 3'h3}, '{1, 9'h040, 3'h0}, '{447, 9'h1FF, 3'h7}, '{1, 9'h000, 3'h0}};
  logic clock_i = 1'b0, rst_n_i = 1'b0, req = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic [2:0] w = 3'h0, store, shift, carry;
  logic [8:0] count;
  logic adv, copy, done, odd;
  int miscompares = 0, n_tests = 0;
  always #20 clock_i = ~clock_i;
  double_rank_counter_shifter u_dut (.clock_i, .rst_n_i, .source_word_i(w),
    .clear_store_i(cmd[4]), .transfer_store_i(cmd[3]), .upstream_word_i(w),
    .load_shift_i(cmd[2]), .rotate_shift_i(cmd[1]), .return_shift_i(cmd[0]), .advance_i(adv),
    .rank_copy_i(copy), .store_word_o(store), .shift_word_o(shift), .count_o(count),
    .carry_enable_o(carry), .phase_odd_o(odd));
  step_sequencer u_seq (.clock_i, .rst_n_i, .req_i(req), .phase_odd_i(odd), .advance_o(adv),
    .rank_copy_o(copy), .done_o(done));
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d bad %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one command pulse, then a quiet edge
  task automatic do_cmd(input logic [4:0] c, input logic [2:0] v);
    @(posedge clock_i) begin cmd <= c; w <= v; end
    @(posedge clock_i) cmd <= 5'h00;
  endtask
  // bounded wait per increment so a stuck sequencer cannot hang the run
  task automatic step(input int n);
    int k;
    @(posedge clock_i) req <= 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin @(posedge clock_i); k++; end while (done !== 1'b1 && k < 20);
      if (k >= 20) begin miscompares++; end_sim(); end
    end
    req <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1 chk({store, shift, count}, 15'h0);
    $display("reset done");
    foreach (rows[i]) begin
      step(rows[i].n);
      repeat (2) @(posedge clock_i);
      #1 chk(count, rows[i].c);
      chk(carry, rows[i].e);
    end
    $display("counter done");
    do_cmd(5'h10, 3'h0);
    do_cmd(5'h08, 3'h5);
    do_cmd(5'h08, 3'h2);
    do_cmd(5'h00, 3'h0);
    #1 chk(store, 3'h7);
    do_cmd(5'h18, 3'h7);
    @(posedge clock_i);
    #1 chk(store, 3'h0);
    $display("store done");
    do_cmd(5'h04, 3'h3);
    do_cmd(5'h02, 3'h0);
    @(posedge clock_i);
    #1 chk(shift, 3'h6);
    do_cmd(5'h01, 3'h0);
    do_cmd(5'h02, 3'h0);
    @(posedge clock_i);
    #1 chk(shift, 3'h5);
    do_cmd(5'h05, 3'h1);
    do_cmd(5'h02, 3'h0);
    @(posedge clock_i);
    #1 chk(shift, 3'h2);
    $display("shift done");
    end_sim();
  end
endmodule

// ---- dv/step_sequencer.sv ----
module step_sequencer (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic req_i,
  input  wire logic phase_odd_i,
  output logic      advance_o,
  output logic      rank_copy_o,
  output wire logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  assign done_o = st == 2'h3;
  // advance in odd cycle, copy two later, never together
  always_ff @(posedge clock_i) begin
    advance_o   <= 1'b0;
    rank_copy_o <= st == 2'h2;
    if (!rst_n_i) st <= 2'h0;
    else if (st != 2'h0) st <= st + 2'h1;
    else if (req_i && !phase_odd_i) begin
      st        <= 2'h1;
      advance_o <= 1'b1;
    end
  end
endmodule

// ---- rtl/double_rank_counter_shifter.sv ----
// Function
// - single-rank register: one flip-flop per stage, storage only
// - clear forces every single-rank stage to zero
// - transfer sets stages whose source bit is one, others unchanged
// - shifter has two ranks; load copies upstream word into first rank
// - circular shift copies first rank rotated left into second rank
// - return transfer copies second rank back unshifted before next shift
// - second rank drives downstream word; controller takes it after shifts
// - three-stage counter counts upward in binary, 000 to 111
// - on advance, first-rank stage takes complement of second-rank bit
// - stage changes only if all lower second-rank stages hold one
// - advance alters only first rank; transfer copies count across
// - advance at 111 gives 000; transfer returns both ranks to 000
// - each unit outputs carry enable when it holds 111
// - higher unit advances only when all lower carry enables active
// - gated advance formed in clocked delay, sampled in odd phase
// - two-phase clock; each clocked circuit assigned odd or even phase (only the control delay here; other registers clock every edge)
// - control delay takes inputs one phase, outputs the opposite phase
module double_rank_counter_shifter
  import rank_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic [STAGES-1:0]   source_word_i,
  input  wire logic                clear_store_i,
  input  wire logic                transfer_store_i,
  input  wire logic [STAGES-1:0]   upstream_word_i,
  input  wire logic                load_shift_i,
  input  wire logic                rotate_shift_i,
  input  wire logic                return_shift_i,
  input  wire logic                advance_i,
  input  wire logic                rank_copy_i,
  output logic      [STAGES-1:0]   store_word_o,
  output logic      [STAGES-1:0]   shift_word_o,
  output logic      [CNT_W-1:0]    count_o,
  output logic      [UNITS-1:0]    carry_enable_o,
  output logic                     phase_odd_o
);

  logic   [STAGES-1:0] store;
  logic   [STAGES-1:0] shift_first;
  logic   [STAGES-1:0] shift_second;
  logic   [CNT_W-1:0]  cnt_first;
  logic   [CNT_W-1:0]  cnt_second;
  phase_t              phase;
  phase_t              next_phase;
  logic   [UNITS-1:0]  unit_ones;
  logic   [UNITS-1:0]  gated_advance;
  logic   [UNITS-1:0]  advance_held;

  // increment of one unit: each stage flips only when lower second-rank bits are ones
  function automatic logic [STAGES-1:0] unit_step(input logic [STAGES-1:0] second);
    logic [STAGES-1:0] result;
    logic              lower_ones;
    result     = second;
    lower_ones = 1'b1;
    for (int s = 0; s < STAGES; s++) begin
      if (lower_ones) begin
        result[s] = ~second[s];
      end
      lower_ones = lower_ones & second[s];
    end
    return result;
  endfunction

  // master clock phase alternates every edge
  // two-phase timing
  assign next_phase = (phase == PHASE_ODD) ? PHASE_EVEN : PHASE_ODD;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      phase <= PHASE_EVEN;
    end else begin
      phase <= next_phase;
    end
  end

  // single-rank register: clear wins over transfer since it prepares for a new word
  // storage only
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      store <= ZERO_WORD;
    end else if (clear_store_i) begin
      store <= ZERO_WORD;
    end else if (transfer_store_i) begin
      store <= store | source_word_i;
    end
  end

  // shifting register, first rank
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_first <= ZERO_WORD;
    end else if (load_shift_i) begin
      shift_first <= upstream_word_i;
    end else if (return_shift_i) begin
      shift_first <= shift_second;
    end
  end

  // shifting register, second rank
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_second <= ZERO_WORD;
    end else if (rotate_shift_i) begin
      shift_second <= {shift_first[STAGES-2:0], shift_first[STAGES-1]};
    end
  end

  // all-ones detect per unit from the second rank, the settled count
  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      assign unit_ones[u] = (cnt_second[u*STAGES +: STAGES] == ONES_WORD);

      if (u == 0) begin : g_low
        assign gated_advance[u] = advance_i;
      end else begin : g_high
        assign gated_advance[u] = advance_i & (&unit_ones[u-1:0]);
      end

      // control delay: inputs caught at the odd phase, shown in the even one.
      // the unit latches only on the odd phase so a gated advance lands once.
      // odd-phase sampling
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          advance_held[u] <= 1'b0;
        end else if (phase == PHASE_ODD) begin
          advance_held[u] <= gated_advance[u];
        end else begin
          advance_held[u] <= 1'b0;
        end
      end

      // counter first rank; wraps 111 to 000 naturally
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          cnt_first[u*STAGES +: STAGES] <= ZERO_WORD;
        end else if (advance_held[u]) begin
          cnt_first[u*STAGES +: STAGES] <= unit_step(cnt_second[u*STAGES +: STAGES]);
        end
      end
    end
  endgenerate

  // counter second rank copies whole count across
  // binary up count
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_second <= '0;
    end else if (rank_copy_i) begin
      cnt_second <= cnt_first;
    end
  end

  // store output, one cycle behind the store itself;
  // the extra cycle keeps every top-level output straight off a flip-flop
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      store_word_o <= ZERO_WORD;
    end else begin
      store_word_o <= store;
    end
  end

  // shifted word towards the downstream register;
  // the controller must wait for its last shift before taking it
  // second rank downstream
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_word_o <= ZERO_WORD;
    end else begin
      shift_word_o <= shift_second;
    end
  end

  // count output shows the settled second rank only,
  // so a half-finished advance is never visible
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else begin
      count_o <= cnt_second;
    end
  end

  // carry enables follow the same rank as the count output,
  // so both always agree in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      carry_enable_o <= '0;
    end else begin
      carry_enable_o <= unit_ones;
    end
  end

  // phase flag tracks the internal phase register edge for edge;
  // the controller uses it to place advances in the odd phase
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      phase_odd_o <= 1'b0;
    end else begin
      phase_odd_o <= (next_phase == PHASE_ODD);
    end
  end

endmodule

// ---- rtl/rank_pkg.sv ----
package rank_pkg;
  // word widths of the building blocks
  localparam int unsigned STAGES     = 3;
  localparam int unsigned UNITS      = 3;
  localparam int unsigned CNT_W      = STAGES * UNITS;
  // reset and extreme values of one counter unit
  localparam logic [STAGES-1:0] ZERO_WORD = 3'h0;
  localparam logic [STAGES-1:0] ONES_WORD = 3'h7;
  // clock phase encoding
  typedef enum logic [0:0] {
    PHASE_EVEN = 1'b0,
    PHASE_ODD  = 1'b1
  } phase_t;
endpackage
